/* File: verilog/hxb_regs.vh */
// Purpose: Constants for the host/expansion address bridge
// Assumes: Included by bare name from the bridge sources
// Notes:   Widths, reset values and default timing counts
`ifndef HXB_REGS_VH
`define HXB_REGS_VH

// Address field positions
`define HXB_HOST_AW        24
`define HXB_EXP_AW         32
`define HXB_AM_W           6
`define HXB_WIN_LSB        16
`define HXB_WIN_MSB        23
`define HXB_OFS_LSB        20
`define HXB_OFS_MSB        23
`define HXB_IO_AW          10

// Reset values
`define HXB_AM_RST         6'h00
`define HXB_PAGE_RST       16'h0000
`define HXB_WIN_RST        8'h00
`define HXB_RANGE_RST      16'h0000
`define HXB_OFS_RST        4'h0

// Address modifier codes decoded by the slave side
`define HXB_AM_A24         6'h39
`define HXB_AM_A16         6'h29

// Default bus timeout period in clock cycles
`define HXB_BTO_DEF        16'h00c8
`define HXB_BTO_W          16

`endif

/* File: verilog/hxb_bto.v */
// Purpose: Expansion bus timeout counter
// Assumes: Single clock, synchronous active-low reset
// Notes:   Period is loaded by software; zero period never times out
`timescale 1ns/1ps
`default_nettype none
`include "hxb_regs.vh"

module hxb_bto #(
	parameter W = `HXB_BTO_W
) (
	// Clock and reset
	input  wire         i_sys_clk,
	input  wire         i_reset_n,
	// Control
	input  wire         i_enable,
	input  wire         i_cycle_active,
	input  wire [W-1:0] i_period,
	// Status
	output reg          o_timeout
);

	reg [W-1:0] count_reg;

	// Count while a cycle is open, pulse once on expiry
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			count_reg <= {W{1'b0}};
			o_timeout <= 1'b0;
		end else if (!i_enable || !i_cycle_active) begin
			count_reg <= {W{1'b0}};
			o_timeout <= 1'b0;
		end else begin
			o_timeout <= (i_period != {W{1'b0}}) && (count_reg == i_period - 1'b1);
			if (count_reg != i_period)
				count_reg <= count_reg + 1'b1;
		end
	end

endmodule // hxb_bto
`default_nettype wire

/* File: verilog/hxb_bridge.v */
// Purpose: Address path of a host / expansion bus bridge
// Assumes: All inputs synchronous to i_sys_clk
// Notes:   Control and configuration bits are plain ports
`timescale 1ns/1ps
`default_nettype none
`include "hxb_regs.vh"

module hxb_bridge #(
	parameter HAW = `HXB_HOST_AW,
	parameter EAW = `HXB_EXP_AW,
	parameter AMW = `HXB_AM_W
) (
	// Clock and reset
	input  wire                    i_sys_clk,
	input  wire                    i_reset_n,
	// Configuration written by host software
	input  wire [AMW-1:0]          i_master_am,
	input  wire [15:0]             i_page,
	input  wire [7:0]              i_window,
	input  wire [15:0]             i_range_a24,
	input  wire [15:0]             i_range_a16,
	input  wire [3:0]              i_slave_offset,
	input  wire                    i_sysctl_en,
	input  wire [`HXB_BTO_W-1:0]   i_bto_period,
	// Host bus side
	input  wire [HAW-1:0]          i_host_addr,
	input  wire                    i_host_addr_valid,
	input  wire                    i_host_mem,
	input  wire                    i_host_cycle_done,
	// Expansion bus side
	input  wire [EAW-1:0]          i_exp_ad,
	input  wire [AMW-1:0]          i_exp_am,
	input  wire                    i_exp_addr_strobe,
	input  wire                    i_exp_data_strobe,
	input  wire                    i_exp_block,
	input  wire                    i_exp_end,
	input  wire                    i_exp_bus_req,
	input  wire                    i_exp_grant_in,
	input  wire                    i_master_bcast,
	input  wire                    i_master_done,
	// Master path outputs
	output reg                     o_expansion_cycle_request,
	output reg  [EAW-1:0]          o_exp_ad,
	output reg                     o_exp_ad_oe_n,
	output reg  [AMW-1:0]          o_exp_am,
	output reg                     o_exp_am_oe_n,
	output reg                     o_exp_owned,
	// Slave path outputs
	output reg                     o_host_cycle_request,
	output reg  [HAW-1:0]          o_slave_host_addr,
	output reg                     o_slave_io,
	output reg                     o_slave_cycle,
	output reg                     o_host_addr_oe,
	output reg                     o_host_data_oe,
	// System controller outputs
	output reg                     o_exp_grant_out,
	output reg                     o_bus_timeout
);

	// Slave sequencer states
	localparam S_IDLE = 2'b00;
	localparam S_ADDR = 2'b01;
	localparam S_DATA = 2'b10;
	localparam S_NEXT = 2'b11;

	reg [HAW-1:0] host_addr_reg;
	reg           host_mem_reg;
	reg [EAW-1:0] slave_addr_reg;
	reg [AMW-1:0] slave_am_reg;
	reg [1:0]     state_reg;
	reg [1:0]     state_next;
	reg           owned_reg;
	reg           win_hit;
	reg           a24_hit;
	reg           a16_hit;
	reg [3:0]     mapped_top;
	wire          bto_pulse;

	// Host address latch, held until the next valid host address
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			host_addr_reg <= {HAW{1'b0}};
			host_mem_reg  <= 1'b0;
		end else if (i_host_addr_valid) begin
			host_addr_reg <= i_host_addr;
			host_mem_reg  <= i_host_mem;
		end
	end

	// Master window decode
	always @* begin
		win_hit = host_mem_reg &&
			(host_addr_reg[`HXB_WIN_MSB:`HXB_WIN_LSB] == i_window);
	end

	// Expansion ownership: taken on grant while requesting, kept until done or bus timeout
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			owned_reg       <= 1'b0;
			o_exp_grant_out <= 1'b0;
		end else begin
			if (o_expansion_cycle_request && i_exp_grant_in)
				owned_reg <= 1'b1;
			else if (i_master_done || bto_pulse)
				owned_reg <= 1'b0;
			// Pass grant down the chain when neither asking for it nor owning the bus
			o_exp_grant_out <= i_exp_grant_in && !o_expansion_cycle_request &&
				!owned_reg;
		end
	end

	// Master outputs: request, broadcast address and modifier lines
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_expansion_cycle_request <= 1'b0;
			o_exp_ad                  <= {EAW{1'b0}};
			o_exp_ad_oe_n             <= 1'b1;
			o_exp_am                  <= `HXB_AM_RST;
			o_exp_am_oe_n             <= 1'b1;
			o_exp_owned               <= 1'b0;
		end else begin
			o_expansion_cycle_request <= win_hit && !i_master_done &&
				!i_host_cycle_done;
			o_exp_ad      <= {i_page, host_addr_reg[15:0]};
			o_exp_ad_oe_n <= !(owned_reg && i_master_bcast);
			o_exp_am      <= i_master_am;
			o_exp_am_oe_n <= !owned_reg;
			o_exp_owned   <= owned_reg;
		end
	end

	// Slave address latch and block counter
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			slave_addr_reg <= {EAW{1'b0}};
			slave_am_reg   <= `HXB_AM_RST;
		end else if (i_exp_addr_strobe && state_reg == S_IDLE) begin
			slave_addr_reg <= i_exp_ad;
			slave_am_reg   <= i_exp_am;
		end else if (state_reg == S_NEXT) begin
			slave_addr_reg <= slave_addr_reg + 1'b1;
		end
	end

	// Slave decode against the two range registers
	always @* begin
		a24_hit = (slave_am_reg == `HXB_AM_A24) &&
			(slave_addr_reg[23:20] == i_range_a24[3:0]);
		a16_hit = (slave_am_reg == `HXB_AM_A16) &&
			(slave_addr_reg[15:`HXB_IO_AW] == i_range_a16[15:`HXB_IO_AW]);
		mapped_top = slave_addr_reg[`HXB_OFS_MSB:`HXB_OFS_LSB] + i_slave_offset;
	end

	// Slave sequencer next state
	always @* begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE:
				if (i_exp_addr_strobe)
					state_next = S_ADDR;
			S_ADDR:
				if (i_exp_end || !(a24_hit || a16_hit))
					state_next = S_IDLE;
				else if (i_exp_data_strobe)
					state_next = S_DATA;
			S_DATA:
				if (i_exp_end)
					state_next = S_IDLE;
				else if (i_host_cycle_done)
					state_next = i_exp_block ? S_NEXT : S_IDLE;
			S_NEXT:
				state_next = i_exp_end ? S_IDLE : S_ADDR;
			default:
				state_next = S_IDLE;
		endcase
	end

	// Slave sequencer state and outputs
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			state_reg            <= S_IDLE;
			o_host_cycle_request <= 1'b0;
			o_slave_host_addr    <= {HAW{1'b0}};
			o_slave_io           <= 1'b0;
			o_slave_cycle        <= 1'b0;
			o_host_addr_oe       <= 1'b0;
			o_host_data_oe       <= 1'b0;
		end else begin
			state_reg            <= state_next;
			o_host_cycle_request <= (state_reg != S_IDLE) && (a24_hit || a16_hit);
			if (a24_hit)
				o_slave_host_addr <= {mapped_top, slave_addr_reg[19:0]};
			else
				o_slave_host_addr <= {{(HAW-`HXB_IO_AW){1'b0}},
					slave_addr_reg[`HXB_IO_AW-1:0]};
			o_slave_io     <= a16_hit;
			o_slave_cycle  <= (state_next == S_DATA);
			// Decode is stale in the capture cycle, so no enable straight from idle
			o_host_addr_oe <= (state_next == S_DATA) || (state_next == S_ADDR &&
				state_reg != S_IDLE && (a24_hit || a16_hit));
			o_host_data_oe <= (state_next == S_DATA);
		end
	end

	// Bus timeout unit, part of the system controller
	hxb_bto #(
		.W (`HXB_BTO_W)
	) u_bto (
		.i_sys_clk      (i_sys_clk),
		.i_reset_n      (i_reset_n),
		.i_enable       (i_sysctl_en),
		.i_cycle_active (i_exp_bus_req || owned_reg),
		.i_period       (i_bto_period),
		.o_timeout      (bto_pulse)
	);

	// Timeout output register
	always @(posedge i_sys_clk) begin
		if (!i_reset_n)
			o_bus_timeout <= 1'b0;
		else
			o_bus_timeout <= bto_pulse;
	end

endmodule // hxb_bridge
`default_nettype wire

/* File: bench/hxb_assertions.sv */
// Purpose: Port-level checks on the bridge
// Assumes: Bound to hxb_bridge, config held steady
// Notes:   One clock domain, sync reset disables all
`timescale 1ns/1ps
`default_nettype none
module hxb_chk (
	input wire logic        i_sys_clk, i_reset_n, i_host_addr_valid, i_host_mem,
	input wire logic        i_host_cycle_done,
	input wire logic        i_master_done, i_exp_addr_strobe, i_exp_block, i_sysctl_en,
	input wire logic [5:0]  i_master_am, i_exp_am, o_exp_am,
	input wire logic [15:0] i_page, i_range_a24,
	input wire logic [7:0]  i_window,
	input wire logic [23:0] i_host_addr, o_slave_host_addr,
	input wire logic [31:0] i_exp_ad, o_exp_ad,
	input wire logic        o_expansion_cycle_request, o_exp_ad_oe_n, o_exp_am_oe_n,
	input wire logic        o_exp_owned, o_host_cycle_request, o_slave_cycle, o_bus_timeout
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	// Window hit latched, then a cycle without completion
	sequence s_hit;
		i_host_addr_valid && i_host_mem && i_host_addr[23:16] == i_window && !i_master_done
		##1 !i_master_done && !i_host_cycle_done;
	endsequence
	// Idle A24 broadcast inside the programmed range
	sequence s_a24;
		i_exp_addr_strobe && !o_slave_cycle && !o_host_cycle_request && i_exp_am == 6'h39
		&& i_exp_ad[23:20] == i_range_a24[3:0];
	endsequence
	property p_am_owned; o_exp_owned |-> !o_exp_am_oe_n && o_exp_am == i_master_am; endproperty
	a_am_owned: assert property (p_am_owned) else $error("modifier not driven");
	property p_bcast; !o_exp_ad_oe_n |-> o_exp_ad[31:16] == i_page; endproperty
	a_bcast: assert property (p_bcast) else $error("page bits wrong");
	property p_win_hit; s_hit |=> o_expansion_cycle_request; endproperty
	a_win_hit: assert property (p_win_hit) else $error("window hit missed");
	property p_win_miss;
		i_host_addr_valid && !i_host_mem ##1 !i_host_addr_valid |-> ##1 !o_expansion_cycle_request;
	endproperty
	a_win_miss: assert property (p_win_miss) else $error("I/O cycle hit window");
	property p_bto_pulse; o_bus_timeout |=> !o_bus_timeout; endproperty
	a_bto_pulse: assert property (p_bto_pulse) else $error("timeout not a pulse");
	property p_sys_off; !i_sysctl_en [*2] |-> !o_bus_timeout; endproperty
	a_sys_off: assert property (p_sys_off) else $error("timeout while disabled");
	property p_a24; s_a24 |-> ##2 o_host_cycle_request; endproperty
	a_a24: assert property (p_a24) else $error("slave request missed");
	property p_hold;
		o_slave_cycle && !i_exp_block ##1 o_slave_cycle && !i_exp_block
		|-> $stable(o_slave_host_addr);
	endproperty
	a_hold: assert property (p_hold) else $error("slave address moved");
endmodule // hxb_chk
bind hxb_bridge hxb_chk hxb_chk_i (.*);
`default_nettype wire

/* File: bench/hxb_far.sv */
// Purpose: Arbiter and remote slave stand-in
// Assumes: Request is a level from the bridge
// Notes:   Grant is one pulse, cycle ends after a fixed delay
`timescale 1ns/1ps
`default_nettype none
module hxb_far (
	input  wire logic i_sys_clk,
	input  wire logic i_reset_n,
	input  wire logic i_req,
	input  wire logic i_owned,
	output var  logic o_grant,
	output var  logic o_done
);
	logic [3:0] cnt_reg;
	// Count busy cycles, grant early, end the cycle late
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			cnt_reg <= 4'h0;
			o_grant <= 1'h0;
			o_done  <= 1'h0;
		end else begin
			cnt_reg <= (i_req || i_owned) ? cnt_reg + 4'h1 : 4'h0;
			o_grant <= i_req && !i_owned && cnt_reg == 4'h2;
			o_done  <= i_owned && cnt_reg == 4'hc;
		end
	end
endmodule // hxb_far
`default_nettype wire

/* File: bench/hxb_bridge_test.sv */
// Purpose: Self-checking bench for the address bridge
// Assumes: Inputs change on the falling edge
// Notes:   Config held steady within each scenario
`timescale 1ns/1ps
`default_nettype none
module hxb_bridge_test;
	logic        i_sys_clk = 1'h0, i_reset_n = 1'h0, i_sysctl_en = 1'h0, i_host_mem = 1'h0;
	logic        i_host_addr_valid = 1'h0, i_host_cycle_done = 1'h0, i_exp_addr_strobe = 1'h0;
	logic        i_exp_data_strobe = 1'h0, i_exp_block = 1'h0, i_exp_end = 1'h0;
	logic        i_exp_bus_req = 1'h0, i_master_bcast = 1'h0, i_exp_grant_in, i_master_done;
	logic [5:0]  i_master_am = 6'h3d, i_exp_am = 6'h00, o_exp_am;
	logic [15:0] i_page = 16'hbeef, i_range_a24 = 16'h0005, i_range_a16 = 16'hc400;
	logic [15:0] i_bto_period = 16'h0005;
	logic [7:0]  i_window = 8'h0c;
	logic [3:0]  i_slave_offset = 4'h3;
	logic [23:0] i_host_addr = 24'h0, o_slave_host_addr;
	logic [31:0] i_exp_ad = 32'h0, o_exp_ad;
	logic        o_expansion_cycle_request, o_exp_ad_oe_n, o_exp_am_oe_n, o_exp_owned;
	logic        o_host_cycle_request, o_slave_io, o_slave_cycle, o_host_addr_oe;
	logic        o_host_data_oe, o_exp_grant_out, o_bus_timeout;
	int          miscompares = 0, checks = 0, n;
	hxb_bridge hxb_bridge_i (.*);
	hxb_far hxb_far_i (.i_sys_clk, .i_reset_n, .i_req(o_expansion_cycle_request),
		.i_owned(o_exp_owned), .o_grant(i_exp_grant_in), .o_done(i_master_done));
	// Free-running clock
	always #2.5 i_sys_clk = ~i_sys_clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		$display("Comparisons %0d, mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task tick(input int k); repeat (k) @(negedge i_sys_clk); endtask
	// Ends the run when a bounded wait ran out
	task bound; if (n >= 40) begin miscompares++; report_and_stop; end endtask
	// Restart the timeout unit with period p and time its pulse
	task bto_run(input logic [15:0] p);
		i_bto_period = p;
		i_sysctl_en = 1'h1;
		i_exp_bus_req = 1'h0;
		tick(2);
		i_exp_bus_req = 1'h1;
		for (n = 0; n < 40 && !o_bus_timeout; n++) tick(1);
		bound;
		chk(n >= p && n <= p + 16'h2, 1'h1);
	endtask
	// Host access and expected window decision
	task host(input logic [23:0] a, input logic mem, input logic hit);
		i_host_addr = a; i_host_mem = mem; i_host_addr_valid = 1'h1;
		tick(1);
		i_host_addr_valid = 1'h0;
		tick(2);
		chk(o_expansion_cycle_request, hit);
	endtask
	// Remote broadcast, then data phase if it maps to the host
	task slave(input logic [31:0] ad, input logic [5:0] am, input logic hit,
		input logic [23:0] ha, input logic io);
		i_exp_ad = ad; i_exp_am = am; i_exp_addr_strobe = 1'h1;
		tick(1);
		i_exp_addr_strobe = 1'h0; i_exp_ad = ~ad;
		tick(2);
		chk(o_host_cycle_request, hit);
		chk(o_host_addr_oe, hit);
		if (hit) begin
			chk(o_slave_host_addr, ha);
			chk(o_slave_io, io);
			i_exp_data_strobe = 1'h1;
			for (n = 0; n < 40 && !o_slave_cycle; n++) tick(1);
			bound;
			tick(2);
			chk(o_slave_cycle, 1'h1);
			chk(o_host_data_oe, 1'h1);
			i_host_cycle_done = 1'h1; tick(1); i_host_cycle_done = 1'h0;
			i_exp_data_strobe = 1'h0; tick(2);
			if (i_exp_block) chk(o_slave_host_addr, ha + 24'h1);
		end
		i_exp_end = 1'h1; tick(1); i_exp_end = 1'h0; tick(2);
	endtask
	initial begin
		tick(8);
		i_reset_n = 1'h1;
		tick(1);
		host(24'h0c1234, 1'h1, 1'h1);
		for (n = 0; n < 40 && !o_exp_owned; n++) begin
			tick(1);
			chk(o_exp_grant_out, 1'h0);
		end
		bound;
		chk(o_exp_am, i_master_am);
		i_host_addr = 24'h0; i_host_mem = 1'h0; i_master_bcast = 1'h1; tick(1);
		i_master_bcast = 1'h0;
		chk(o_exp_ad, {i_page, 16'h1234});
		chk(o_exp_ad_oe_n, 1'h0);
		for (n = 0; n < 40 && o_exp_owned; n++) tick(1);
		bound;
		chk(o_exp_am_oe_n, 1'h1);
		host(24'h0d1234, 1'h1, 1'h0);
		host(24'h0c1234, 1'h0, 1'h0);
		slave(32'h00500010, 6'h39, 1'h1, 24'h800010, 1'h0);
		i_exp_block = 1'h1;
		slave(32'h005000ff, 6'h39, 1'h1, 24'h8000ff, 1'h0);
		i_exp_block = 1'h0;
		i_range_a24 = 16'h000f;
		slave(32'h00f00020, 6'h39, 1'h1, 24'h200020, 1'h0);
		slave(32'h0000c4aa, 6'h29, 1'h1, 24'h0000aa, 1'h1);
		slave(32'h00f00010, 6'h3d, 1'h0, 24'h0, 1'h0);
		slave(32'h00000400, 6'h29, 1'h0, 24'h0, 1'h0);
		bto_run(16'h0005);
		bto_run(16'h000a);
		i_sysctl_en = 1'h0;
		i_exp_bus_req = 1'h0;
		tick(2);
		i_exp_bus_req = 1'h1;
		n = 0;
		repeat (20) begin tick(1); if (o_bus_timeout) n++; end
		chk(n, 32'h0);
		report_and_stop;
	end
endmodule // hxb_bridge_test
`default_nettype wire
